// file: design/touch_key_scan_control.v
// Design decisions made here: the APB slave port and the address map.
`include "touch_key_scan_defs.vh"
`default_nettype none

module touch_key_scan_control #(
    parameter NKEYS       = 24,
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset.
    input  wire                 CLOCK_I,
    input  wire                 RST_B_I,
    // APB slave.
    input  wire                 PSEL_I,
    input  wire                 PENABLE_I,
    input  wire                 PWRITE_I,
    input  wire [11:0]          PADDR_I,
    input  wire [31:0]          PWDATA_I,
    output reg  [31:0]          PRDATA_O,
    output reg                  PREADY_O,
    output reg                  PSLVERR_O,
    // Acquisition datapath.
    input  wire [NKEYS-1:0]     DETECT_I,
    input  wire [NKEYS-1:0]     ABOVE_POS_I,
    input  wire [NKEYS*8-1:0]   DEVIATION_I,
    output reg  [NKEYS-1:0]     RECAL_O,
    output reg  [NKEYS-1:0]     DRIFT_ALLOW_O,
    output reg                  BURST_END_O,
    // Matrix drive.
    output reg                  DRIVE_O,
    output reg                  RECV_EN_O,
    output reg  [4:0]           KEY_SEL_O,
    output reg                  SCOPE_SYNC_O,
    // System pins.
    input  wire                 LINE_SYNC_I,
    output reg                  CHANGE_O,
    output reg                  FAST_MODE_O
);

    // =================================================================
    // Declarations.
    localparam [3:0] S_SLEEP = 4'b0001;
    localparam [3:0] S_WAIT  = 4'b0010;
    localparam [3:0] S_CHECK = 4'b0100;
    localparam [3:0] S_BURST = 4'b1000;

    reg  [13:0]      key_cfg_reg [0:NKEYS-1];
    reg  [7:0]       global_reg;
    reg  [7:0]       awake_cfg_reg;
    reg  [7:0]       drift_hold_cfg_reg;
    reg  [NKEYS-1:0] recal_cmd_reg;
    reg  [NKEYS-1:0] key_state_reg;
    reg  [NKEYS-1:0] key_state_next;
    reg  [NKEYS-1:0] suppressed;
    wire [NKEYS-1:0] recal_due;
    reg  [NKEYS-1:0] wake_mask;
    reg  [NKEYS-1:0] enable_mask;
    reg  [NKEYS-1:0] scope_mask;
    reg  [31:0]      tick_cnt_reg;
    reg              ms_tick_reg;
    reg  [6:0]       cnt100_reg;
    reg  [8:0]       cnt500_reg;
    reg              tick100_reg;
    reg              tick500_reg;
    reg  [2:0]       sync_ff_reg;
    reg              sync_level_reg;
    reg  [3:0]       state_reg;
    reg  [11:0]      wait_ms_reg;
    reg  [4:0]       key_idx_reg;
    reg  [6:0]       pulse_cnt_reg;
    reg              phase_reg;
    reg  [7:0]       awake_cnt_reg;
    reg  [7:0]       hold_cnt_reg;
    reg  [11:0]      sleep_ms;
    reg  [6:0]       pulse_last;
    reg  [13:0]      cur_cfg;
    reg  [31:0]      rd_data;
    reg              rd_err;
    wire             shift_mode   = global_reg[`GC_SHIFT_BIT];
    wire             line_sync_en = global_reg[`GC_LINE_SYNC_BIT];
    wire             apb_access   = PSEL_I & PENABLE_I & PREADY_O;
    wire             apb_wr       = apb_access & PWRITE_I;
    wire [NKEYS-1:0] changed      = key_state_next ^ key_state_reg;
    wire             any_change   = |changed;
    wire             wake_change  = |(changed & wake_mask);
    wire             sync_fall    = sync_level_reg & ~sync_ff_reg[2] & ~sync_ff_reg[1];
    wire [7:0]       awake_load   = shift_mode ? `SHIFT_AWAKE : awake_cfg_reg;
    integer          i;
    integer          j;

    // =================================================================
    // Per-key masks gathered from the configuration words.
    always @* begin
        for (i = 0; i < NKEYS; i = i + 1) begin
            wake_mask[i]   = key_cfg_reg[i][`KC_WAKE_BIT] | shift_mode; // [RQ14] [RQ17]
            enable_mask[i] = key_cfg_reg[i][`KC_ENABLE_BIT];
            scope_mask[i]  = key_cfg_reg[i][`KC_SCOPE_BIT];
        end
    end

    // Competing-key suppression on raw deviations, ignoring position and gain.
    always @* begin
        suppressed = {NKEYS{1'b0}};
        for (i = 0; i < NKEYS; i = i + 1) begin
            for (j = 0; j < NKEYS; j = j + 1) begin
                if (i != j && key_cfg_reg[i][`KC_SUPPRESS_BIT] &&
                    key_cfg_reg[j][`KC_SUPPRESS_BIT] &&
                    $signed(DEVIATION_I[j*8 +: 8]) < $signed(DEVIATION_I[i*8 +: 8])) begin
                    suppressed[i] = 1'b1; // [RQ7] [RQ8]
                end
            end
        end
    end

    // Next key state: detection not suppressed, dropped on recalibration.
    always @* begin
        key_state_next = DETECT_I & ~suppressed & ~RECAL_O; // [RQ20]
    end

    // =================================================================
    // Time base: 1 ms tick, then 100 ms and 500 ms ticks.
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            tick_cnt_reg <= 32'h0000_0000;
            ms_tick_reg  <= 1'b0;
            cnt100_reg   <= 7'h00;
            cnt500_reg   <= 9'h000;
            tick100_reg  <= 1'b0;
            tick500_reg  <= 1'b0;
        end else begin
            ms_tick_reg  <= (tick_cnt_reg == TICK_CYCLES - 1);
            tick_cnt_reg <= (tick_cnt_reg == TICK_CYCLES - 1) ? 32'h0000_0000
                                                              : tick_cnt_reg + 32'h0000_0001;
            tick100_reg  <= 1'b0;
            tick500_reg  <= 1'b0;
            if (ms_tick_reg) begin
                tick100_reg <= (cnt100_reg == `STEP_100MS - 1);
                tick500_reg <= (cnt500_reg == `STEP_HALF_S - 1);
                cnt100_reg  <= (cnt100_reg == `STEP_100MS - 1) ? 7'h00 : cnt100_reg + 7'h01;
                cnt500_reg  <= (cnt500_reg == `STEP_HALF_S - 1) ? 9'h000 : cnt500_reg + 9'h001;
            end
        end
    end

    // Line sync pin synchroniser; a level counts once stages two and three agree.
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            sync_ff_reg    <= 3'h7;
            sync_level_reg <= 1'b1;
        end else begin
            sync_ff_reg <= {sync_ff_reg[1:0], LINE_SYNC_I}; // [RQ12]
            if (sync_ff_reg[2] == sync_ff_reg[1]) begin
                sync_level_reg <= sync_ff_reg[2];
            end
        end
    end

    // =================================================================
    // Per-key recalibration timers.
    genvar k;
    generate
        for (k = 0; k < NKEYS; k = k + 1) begin : g_key
            reg  [16:0] neg_cnt_reg;
            reg  [7:0]  pos_cnt_reg;
            wire [7:0]  neg_recal_delay    = key_cfg_reg[k][`KC_NRD_LSB +: 8];
            // Delay in ms; counting ms keeps the timeout within one ms of the setting.
            wire [31:0] nrd_ms = neg_recal_delay * `STEP_HALF_S;

            // Detection time and positive excursion time, both in ms.
            always @(posedge CLOCK_I) begin
                if (!RST_B_I || RECAL_O[k]) begin
                    neg_cnt_reg <= 17'h00000;
                    pos_cnt_reg <= 8'h00;
                end else begin
                    if (!key_state_reg[k]) begin
                        neg_cnt_reg <= 17'h00000;
                    end else if (ms_tick_reg && neg_cnt_reg != 17'h1ffff) begin
                        neg_cnt_reg <= neg_cnt_reg + 17'h00001; // [RQ3]
                    end
                    if (!ABOVE_POS_I[k]) begin
                        pos_cnt_reg <= 8'h00;
                    end else if (ms_tick_reg && pos_cnt_reg != `POS_RECAL_MS) begin
                        pos_cnt_reg <= pos_cnt_reg + 8'h01;
                    end
                end
            end

            // Zero delay never expires; the illegal value is treated the same way.
            assign recal_due[k] = (neg_recal_delay != 8'h00 && neg_recal_delay != `NRD_ILLEGAL &&
                                   {15'h0000, neg_cnt_reg} >= nrd_ms) ||   // [RQ1] [RQ2]
                                  (pos_cnt_reg == `POS_RECAL_MS) ||        // [RQ4]
                                  recal_cmd_reg[k];
        end
    endgenerate

    // Recalibration strobe, key state and drift permission.
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            RECAL_O       <= {NKEYS{1'b0}};
            key_state_reg <= {NKEYS{1'b0}};
            hold_cnt_reg  <= 8'h00;
            DRIFT_ALLOW_O <= {NKEYS{1'b0}};
        end else begin
            RECAL_O       <= recal_due & ~RECAL_O; // [RQ20]
            key_state_reg <= key_state_next;
            if (|(key_state_next & ~key_state_reg)) begin
                hold_cnt_reg <= drift_hold_cfg_reg; // [RQ18]
            end else if (tick100_reg && hold_cnt_reg != 8'h00) begin
                hold_cnt_reg <= hold_cnt_reg - 8'h01;
            end
            // The old state is included so a recalibration cycle never opens drift.
            DRIFT_ALLOW_O <= ~(key_state_next | key_state_reg) &            // [RQ19]
                             {NKEYS{drift_hold_cfg_reg == 8'h00 || hold_cnt_reg == 8'h00}};
        end
    end

    // =================================================================
    // Fast mode, awake interval and change notification.
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            FAST_MODE_O   <= 1'b0;
            awake_cnt_reg <= 8'h00;
            CHANGE_O      <= 1'b0;
        end else begin
            if (wake_change || (FAST_MODE_O && any_change)) begin
                FAST_MODE_O   <= 1'b1;       // [RQ14]
                awake_cnt_reg <= awake_load; // [RQ15] [RQ17]
            end else if (FAST_MODE_O && tick100_reg) begin
                if (awake_cnt_reg <= 8'h01) begin
                    FAST_MODE_O <= 1'b0;     // [RQ16]
                end
                awake_cnt_reg <= (awake_cnt_reg == 8'h00) ? 8'h00 : awake_cnt_reg - 8'h01;
            end
            // Set wins over a write-one-to-clear in the same cycle.
            if (wake_change && !shift_mode) begin
                CHANGE_O <= 1'b1;            // [RQ14] [RQ17]
            end else if (apb_wr && PADDR_I == `FLAGS_ADDR && PWDATA_I[0]) begin
                CHANGE_O <= 1'b0;
            end
        end
    end

    // =================================================================
    // Sleep length and pulse count lookups.
    always @* begin
        case (global_reg[`GC_SLEEP_LSB +: 3])
            3'h0:    sleep_ms = `SLEEP_MS_0;
            3'h1:    sleep_ms = `SLEEP_MS_1;
            3'h2:    sleep_ms = `SLEEP_MS_2;
            3'h3:    sleep_ms = `SLEEP_MS_3; // [RQ13]
            3'h4:    sleep_ms = `SLEEP_MS_4;
            3'h5:    sleep_ms = `SLEEP_MS_5;
            3'h6:    sleep_ms = `SLEEP_MS_6;
            default: sleep_ms = `SLEEP_MS_7;
        endcase
        cur_cfg    = key_cfg_reg[key_idx_reg];
        pulse_last = {cur_cfg[`KC_BL_LSB +: 2] + 2'h1, 4'h0} - 7'h01 + 7'h00; // [RQ6]
        if (cur_cfg[`KC_BL_LSB +: 2] == 2'h3) begin
            pulse_last = 7'h3f;
        end
    end

    // Scan sequencer: sleep, wait for line sync, walk keys, burst each enabled key.
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            state_reg     <= S_WAIT;
            wait_ms_reg   <= 12'h000;
            key_idx_reg   <= 5'h00;
            pulse_cnt_reg <= 7'h00;
            phase_reg     <= 1'b0;
            DRIVE_O       <= 1'b0;
            RECV_EN_O     <= 1'b0;
            KEY_SEL_O     <= 5'h00;
            SCOPE_SYNC_O  <= 1'b0;
            BURST_END_O   <= 1'b0;
        end else begin
            BURST_END_O <= 1'b0;
            case (state_reg)
                S_SLEEP: begin
                    if (FAST_MODE_O || wait_ms_reg >= sleep_ms) begin
                        state_reg   <= S_WAIT; // [RQ13]
                        wait_ms_reg <= 12'h000;
                    end else if (ms_tick_reg) begin
                        wait_ms_reg <= wait_ms_reg + 12'h001;
                    end
                end
                S_WAIT: begin
                    if (!line_sync_en || sync_fall ||
                        wait_ms_reg >= `LINE_SYNC_WAIT_MS) begin
                        state_reg   <= S_CHECK; // [RQ11]
                        key_idx_reg <= 5'h00;
                    end else if (ms_tick_reg) begin
                        wait_ms_reg <= wait_ms_reg + 12'h001;
                    end
                end
                S_CHECK: begin
                    if (enable_mask[key_idx_reg]) begin
                        state_reg     <= S_BURST;
                        KEY_SEL_O     <= key_idx_reg;
                        RECV_EN_O     <= 1'b1;
                        SCOPE_SYNC_O  <= scope_mask[key_idx_reg]; // [RQ10]
                        pulse_cnt_reg <= 7'h00;
                        phase_reg     <= 1'b0;
                    end else if (key_idx_reg == NKEYS - 1) begin
                        state_reg   <= FAST_MODE_O ? S_WAIT : S_SLEEP;
                        wait_ms_reg <= 12'h000;
                    end else begin
                        key_idx_reg <= key_idx_reg + 5'h01;
                    end
                end
                S_BURST: begin
                    phase_reg <= ~phase_reg;
                    DRIVE_O   <= ~phase_reg & (pulse_cnt_reg <= pulse_last); // [RQ5]
                    if (phase_reg) begin
                        if (pulse_cnt_reg == pulse_last + 7'h01) begin
                            RECV_EN_O    <= 1'b0;
                            SCOPE_SYNC_O <= 1'b0;
                            BURST_END_O  <= 1'b1;
                            if (key_idx_reg == NKEYS - 1) begin
                                state_reg   <= FAST_MODE_O ? S_WAIT : S_SLEEP;
                                wait_ms_reg <= 12'h000;
                            end else begin
                                state_reg   <= S_CHECK;
                                key_idx_reg <= key_idx_reg + 5'h01;
                            end
                        end else begin
                            pulse_cnt_reg <= pulse_cnt_reg + 7'h01;
                        end
                    end
                end
                default: begin
                    state_reg <= S_WAIT;
                end
            endcase
        end
    end

    // =================================================================
    // APB read mux and decode.
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (PADDR_I < `KEY_CFG_BASE + NKEYS * 4 && PADDR_I[1:0] == 2'h0) begin
            rd_data[13:0] = key_cfg_reg[PADDR_I[6:2]];
        end else begin
            case (PADDR_I)
                `GLOBAL_CFG_ADDR: rd_data[7:0]       = global_reg;
                `AWAKE_ADDR:      rd_data[7:0]       = awake_cfg_reg;
                `DRIFT_HOLD_ADDR: rd_data[7:0]       = drift_hold_cfg_reg;
                `KEY_STATE_ADDR:  rd_data[NKEYS-1:0] = key_state_reg;
                `FLAGS_ADDR:      rd_data[2:0]       = {~state_reg[0], FAST_MODE_O, CHANGE_O};
                `RECAL_CMD_ADDR:  rd_data            = 32'h0000_0000;
                default:          rd_err             = 1'b1;
            endcase
        end
    end

    // APB slave: one wait state, writes take effect on the edge with pready high.
    always @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            PREADY_O           <= 1'b0;
            PRDATA_O           <= 32'h0000_0000;
            PSLVERR_O          <= 1'b0;
            global_reg         <= `GC_RESET;
            awake_cfg_reg      <= `AWAKE_RESET;
            drift_hold_cfg_reg <= `DRIFT_HOLD_RESET;
            recal_cmd_reg      <= {NKEYS{1'b0}};
            for (i = 0; i < NKEYS; i = i + 1) begin
                key_cfg_reg[i] <= `KC_RESET; // [RQ9]
            end
        end else begin
            PREADY_O      <= PSEL_I & PENABLE_I & ~PREADY_O;
            PRDATA_O      <= rd_data;
            PSLVERR_O     <= PSEL_I & PENABLE_I & ~PREADY_O & rd_err;
            recal_cmd_reg <= {NKEYS{1'b0}};
            if (apb_wr && !PSLVERR_O) begin
                if (PADDR_I < `KEY_CFG_BASE + NKEYS * 4) begin
                    key_cfg_reg[PADDR_I[6:2]] <= PWDATA_I[13:0]; // [RQ3]
                end else begin
                    case (PADDR_I)
                        `GLOBAL_CFG_ADDR: global_reg         <= PWDATA_I[7:0];
                        `AWAKE_ADDR:      awake_cfg_reg      <= PWDATA_I[7:0];
                        `DRIFT_HOLD_ADDR: drift_hold_cfg_reg <= PWDATA_I[7:0];
                        `RECAL_CMD_ADDR:  recal_cmd_reg      <= PWDATA_I[NKEYS-1:0]; // [RQ2]
                        default:          recal_cmd_reg      <= {NKEYS{1'b0}};
                    endcase
                end
            end
        end
    end

endmodule // touch_key_scan_control

`default_nettype wire

// file: inc/touch_key_scan_defs.vh
// Function
// [RQ1] Recalibrate key after detection outlasts delay
// [RQ2] Delay zero means never auto recalibrate
// [RQ3] Delay byte 0..254 in half seconds
// [RQ4] Recalibrate after 200ms above positive threshold
// [RQ5] Pulse drive line once, receive enabled
// [RQ6] Burst code selects 16/32/48/64 pulses
// [RQ7] Suppress key if rival more negative
// [RQ8] Compare raw deviations of all suppressing keys
// [RQ9] Suppression enable resets to off
// [RQ10] Sync pulse brackets bursts of selected keys
// [RQ11] Line sync edge starts scan, 100ms limit
// [RQ12] Line sync source gives clean logic level
// [RQ13] Sleep/wake cycle, eight durations, default 125ms
// [RQ14] Wake key change enters fast mode, notifies
// [RQ15] Any change while awake restarts interval
// [RQ16] Leave fast mode after awake timeout
// [RQ17] Shift mode: all wake, no notify, 2.5s
// [RQ18] Detection holds drift on all keys
// [RQ19] Drift only while key not detecting
// [RQ20] Recalibration resets reference and detection state
`ifndef TOUCH_KEY_SCAN_DEFS_VH
`define TOUCH_KEY_SCAN_DEFS_VH

// =====================================================================
// Register offsets (byte addresses).
`define KEY_CFG_BASE      12'h000
`define GLOBAL_CFG_ADDR   12'h100
`define AWAKE_ADDR        12'h104
`define DRIFT_HOLD_ADDR   12'h108
`define KEY_STATE_ADDR    12'h10c
`define FLAGS_ADDR        12'h110
`define RECAL_CMD_ADDR    12'h114

// =====================================================================
// Per-key and global configuration word layouts and reset values.
`define KC_NRD_LSB        0
`define KC_BL_LSB         8
`define KC_SUPPRESS_BIT   10
`define KC_SCOPE_BIT      11
`define KC_WAKE_BIT       12
`define KC_ENABLE_BIT     13
`define KC_RESET          14'h3214
`define GC_SLEEP_LSB      0
`define GC_LINE_SYNC_BIT  6
`define GC_SHIFT_BIT      7
`define GC_RESET          8'h03
`define AWAKE_RESET       8'h19
`define DRIFT_HOLD_RESET  8'h0a
`define NRD_ILLEGAL       8'hff

// =====================================================================
// Times and cycle counts.
`define CLOCK_HZ          20000000
`define TICK_MS           1
`define TICK_CYCLES       ((`CLOCK_HZ / 1000) * `TICK_MS)
`define POS_RECAL_MS      200
`define LINE_SYNC_WAIT_MS 100
`define STEP_100MS        100
`define STEP_HALF_S       500
`define SHIFT_AWAKE       8'h19
`define BURST_UNIT        16

// =====================================================================
// Sleep durations in milliseconds, selected by a 3-bit index.
`define SLEEP_MS_0        12'd16
`define SLEEP_MS_1        12'd32
`define SLEEP_MS_2        12'd64
`define SLEEP_MS_3        12'd125
`define SLEEP_MS_4        12'd250
`define SLEEP_MS_5        12'd500
`define SLEEP_MS_6        12'd1000
`define SLEEP_MS_7        12'd2000

`endif

// file: sim/key_matrix_model.sv
`default_nettype none
// ====
// Electrode matrix: counts charge transfers received per burst.
module key_matrix_model (
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic       drive_i,
    input wire logic       recv_en_i,
    input wire logic [4:0] key_sel_i,
    output var logic [7:0] count_o,
    output var logic [4:0] key_o,
    output var logic       done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] acc_reg;
    logic       en_reg;
    // Charge only lands while the receive line is enabled.
    always @(posedge clk_i) begin
        en_reg <= recv_en_i && rst_b_i;
        done_o <= en_reg && !recv_en_i && rst_b_i;
        if (recv_en_i && !en_reg) begin
            key_o <= key_sel_i;
            acc_reg <= {7'h00, drive_i};
        end else if (drive_i && recv_en_i) begin
            acc_reg <= acc_reg + 8'h01;
        end
        if (en_reg && !recv_en_i) begin
            count_o <= acc_reg;
        end
    end
endmodule // key_matrix_model
`default_nettype wire

// file: sim/tb_touch_key_scan_control.sv
`default_nettype none
// ====
// Testbench for the scan control block.
module tb_touch_key_scan_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NK = 24;
    logic          clk, rst_b, psel, pen, pwr, lsync, err, mdone;
    logic          pready, pslverr, bend, drive, recv, scope_pulse_select, chg, fast;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic [NK-1:0] det, apos, recal, dallow;
    logic [4:0]    ksel, mkey;
    logic [7:0]    mcnt;
    int            miscompares, check_count, cyc, r0;
    touch_key_scan_control #(.NKEYS(NK), .TICK_CYCLES(10)) i_dut (
        .CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .DETECT_I(det), .ABOVE_POS_I(apos), .DEVIATION_I('0),
        .RECAL_O(recal), .DRIFT_ALLOW_O(dallow), .BURST_END_O(bend), .DRIVE_O(drive),
        .RECV_EN_O(recv), .KEY_SEL_O(ksel), .SCOPE_SYNC_O(scope_pulse_select), .LINE_SYNC_I(lsync),
        .CHANGE_O(chg), .FAST_MODE_O(fast));
    key_matrix_model i_mat (.clk_i(clk), .rst_b_i(rst_b), .drive_i(drive),
        .recv_en_i(recv), .key_sel_i(ksel), .count_o(mcnt), .key_o(mkey), .done_o(mdone));
    // Clock, cycle ceiling and a tally of key 0 recalibrations.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (recal[0] === 1'b1) r0++;
        if (cyc == 60000) begin
            miscompares++;
            results();
        end
    end
    task automatic results;
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            miscompares++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    // ====
    // Bus cycles and waits.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic wait_fast(input logic v, output int n);
        n = 0;
        while (fast !== v && n < 5000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic wait_recal(output int n);
        n = 0;
        while (recal[1] !== 1'b1 && n < 8000) begin
            @(posedge clk);
            n++;
        end
    endtask
    // ====
    // Scenarios.
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd === 32'h3214 && err === 1'b0, "key cfg reset");
        apb(1'b0, 12'h0fc, 32'h0);
        chk(rd === 32'h0 && err === 1'b1, "unmapped read");
        for (int k = 2; k < NK; k++) wr(12'(4 * k), 32'h0);
    endtask
    task automatic t_burst;
        for (int c = 0; c < 4; c++) begin
            wr(12'h000, 32'h3800 | (c << 8));
            for (int i = 0; i < 2; i++) begin
                do @(posedge clk); while (!(mdone === 1'b1 && mkey === 5'd0));
            end
            chk(mcnt === 8'(16 * (c + 1)), "burst pulse count");
        end
    endtask
    task automatic t_wake;
        int n;
        wr(12'h104, 32'h3);
        wr(12'h004, 32'h2000);
        det[0] <= 1'b1;
        wait_fast(1'b1, n);
        chk(fast === 1'b1 && chg === 1'b1, "wake entry");
        wr(12'h110, 32'h1);
        chk(chg === 1'b0, "change clear");
        repeat (1100) @(posedge clk);
        det[1] <= 1'b1;
        wait_fast(1'b0, n);
        chk(n > 1950 && n < 3050, "awake restart");
    endtask
    task automatic t_nrd;
        int n;
        det[1] <= 1'b0;
        wr(12'h108, 32'h2);
        wr(12'h004, 32'h2001);
        det[1] <= 1'b1;
        wait_recal(n);
        chk(n > 4900 && n < 5100, "negative recal delay");
        chk(dallow[1] === 1'b0, "drift while detecting");
        chk(r0 === 0, "infinite delay recal");
        det <= '0;
    endtask
    task automatic t_hold;
        repeat (1500) @(posedge clk);
        chk(dallow[1] === 1'b1, "drift idle");
        det[0] <= 1'b1;
        repeat (500) @(posedge clk);
        chk(dallow[1] === 1'b0, "drift held");
        repeat (2000) @(posedge clk);
        chk(dallow[1] === 1'b1, "drift resumed");
    endtask
    task automatic t_pos;
        int n;
        apos[1] <= 1'b1;
        wait_recal(n);
        chk(n > 1950 && n < 2050, "positive recal period");
        apos[1] <= 1'b0;
    endtask
    // ====
    // Main sequence.
    initial begin
        rst_b = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = '0; pwdata = '0;
        det = '0; apos = '0;
        lsync = 1'b1;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_burst();
        t_wake();
        t_nrd();
        t_hold();
        t_pos();
        results();
    end
endmodule // tb_touch_key_scan_control
`default_nettype wire

// file: sim/touch_key_scan_control_assertions.sv
`default_nettype none
// ====
// Checker on the scan control ports.
module touch_key_scan_control_assertions #(
    parameter NKEYS = 24
) (
    input wire logic             CLOCK_I,
    input wire logic             RST_B_I,
    input wire logic [NKEYS-1:0] DETECT_I,
    input wire logic [NKEYS-1:0] RECAL_O,
    input wire logic [NKEYS-1:0] DRIFT_ALLOW_O,
    input wire logic             BURST_END_O,
    input wire logic             DRIVE_O,
    input wire logic             RECV_EN_O,
    input wire logic             SCOPE_SYNC_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    a_drive_in_burst: assert property (DRIVE_O |-> RECV_EN_O)
        else $error("Drive pulse outside a burst.");
    a_drive_single: assert property (DRIVE_O |=> !DRIVE_O)
        else $error("Drive pulse longer than one cycle.");
    a_scope_in_burst: assert property (SCOPE_SYNC_O |-> RECV_EN_O)
        else $error("Scope pulse outside a burst.");
    a_scope_drop: assert property (BURST_END_O |-> !SCOPE_SYNC_O)
        else $error("Scope pulse still high at burst end.");
    a_burst_end_close: assert property (BURST_END_O |-> !RECV_EN_O && $past(RECV_EN_O))
        else $error("Burst end without a closing burst.");
    a_recal_single: assert property (|RECAL_O |=> RECAL_O == '0)
        else $error("Recalibration pulse too long.");
    a_detect_no_drift: assert property (DETECT_I[1] |=> !DRIFT_ALLOW_O[1])
        else $error("Drift allowed on a detecting key.");
    a_drift_hold: assert property ($rose(DETECT_I[0]) |-> ##2 (DRIFT_ALLOW_O == '0) [*8])
        else $error("Drift not held after a detection.");
    c_drive: cover property (DRIVE_O);
    c_scope: cover property (SCOPE_SYNC_O);
    c_recal: cover property (RECAL_O[1]);
endmodule // touch_key_scan_control_assertions

bind touch_key_scan_control touch_key_scan_control_assertions #(.NKEYS(NKEYS)) i_chk (
    .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .DETECT_I(DETECT_I), .RECAL_O(RECAL_O),
    .DRIFT_ALLOW_O(DRIFT_ALLOW_O), .BURST_END_O(BURST_END_O), .DRIVE_O(DRIVE_O),
    .RECV_EN_O(RECV_EN_O), .SCOPE_SYNC_O(SCOPE_SYNC_O));
`default_nettype wire
